// ==== src/adc_setup_pkg.sv ====
// constants, field layout and types for the converter setup/readout block
// assumes a 100 MHz system clock and a serial clock supplied by the host
package adc_setup_pkg;
   // widths
   localparam int SETUP_W  = 14;
   localparam int RES_W    = 16;
   localparam int STREAM_W = RES_W + SETUP_W;
   localparam int CNT_W    = 5;
   localparam int SYNC_W   = 3;

   // setup word field positions
   localparam int OVERWRITE_BIT         = 13;
   localparam int INPUT_MODE_SELECT_HI  = 12;
   localparam int INPUT_MODE_SELECT_LO  = 10;
   localparam int CHANNEL_PICK_HI       = 9;
   localparam int CHANNEL_PICK_LO       = 7;
   localparam int BANDWIDTH_BIT         = 6;
   localparam int VSRC_HI               = 5;
   localparam int VSRC_LO               = 3;
   localparam int SCAN_HI               = 2;
   localparam int SCAN_LO               = 1;
   localparam int SETUP_ECHO_DISABLE_BIT = 0;

   // value of the active setup word after reset
   localparam logic [SETUP_W-1:0] SETUP_RST = 14'h3FFF;

   // voltage-source field codes (internal reference is 4.096 V)
   localparam logic [2:0] VSRC_INT_TEMP = 3'h1;
   localparam logic [2:0] VSRC_EXT_TEMP = 3'h2;
   localparam logic [2:0] VSRC_BUF_TEMP = 3'h3;
   localparam logic [2:0] VSRC_EXT      = 3'h6;
   localparam logic [2:0] VSRC_BUF      = 3'h7;

   // channel_scan_control codes
   localparam logic [1:0] SCAN_OFF    = 2'h0;
   localparam logic [1:0] SCAN_UPDATE = 2'h1;
   localparam logic [1:0] SCAN_TEMP   = 2'h2;
   localparam logic [1:0] SCAN_NOTEMP = 2'h3;

   // serial counts
   localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
   localparam logic [CNT_W-1:0] CAP_BITS  = 5'h0E;
   localparam logic [CNT_W-1:0] LEN_DATA  = 5'h10;
   localparam logic [CNT_W-1:0] LEN_ECHO  = 5'h1E;

   // conversion_time and its cycle count at the system clock rate
   localparam int SYS_CLK_MHZ  = 100;
   localparam int CONV_TIME_NS = 1600;
   localparam int CONV_CYC     = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;

   typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
endpackage

// ==== src/adc_setup_ctrl.sv ====
// setup-word capture, conversion timing and serial result readout
// assumes sck comes from the host and stands still outside frames;
// result_in is stable from the converter core at end of conversion

//Contract
// - voltage-source field [5:3] picks reference, buffer and temperature sensor enable.
// - scan field [2:1]: off, update during scan, scan with or without temperature.
// - echo-disable bit 0 low appends the setup word after the result.
// - end of conversion gates setup commit and result readout in every mode.
// - strobe high at end of conversion disables busy indication.
// - incomplete setup word at end of conversion is dropped, setup kept.
// - without busy, unread result is lost; output loads new result's top bit.
// - strobe falling after end of conversion drives output with the top bit.
// - each serial-clock falling edge advances output; first shows the second bit, or the top bit with busy.
// - strobe low at end of conversion enables busy indication.
// - with busy, unfinished readout leaves the last shifted bit driven.
// - busy is a fall to low; a low held bit gives no busy.
// - top setup bit one overwrites the setup, zero keeps it.
// - setup bits sampled on first 14 rising serial edges while strobe low.
// - strobe rising starts conversion, releases output; conversion then runs out.
// - with busy, end of conversion pulls the output low.
module adc_setup_ctrl #(
   parameter int CONV_CYCLES = adc_setup_pkg::CONV_CYC
) (
   // system clock and reset
   input  wire logic                               clk_sys,
   input  wire logic                               rst_n,
   // serial link from the host
   input  wire logic                               sck,
   input  wire logic                               convert_strobe,
   input  wire logic                               sdi,
   output logic                                    serial_out_pin_o,
   output logic                                    serial_out_pin_oe_n,
   // converter core
   input  wire logic [adc_setup_pkg::RES_W-1:0]    result_in,
   output logic                                    conv_active_q,
   output logic                                    eoc_q,
   output logic                                    busy_en_q,
   // active setup and its decodes
   output logic [adc_setup_pkg::SETUP_W-1:0]       setup_word_q,
   output logic                                    ref_int_en_q,
   output logic                                    ref_buf_en_q,
   output logic                                    temp_en_q,
   output logic                                    scan_en_q,
   output logic                                    scan_temp_q,
   output logic                                    scan_update_q
);
   import adc_setup_pkg::*;

   if (CONV_CYCLES < 8 || CONV_CYCLES > 65535) begin : g_bad_conv
      $error("CONV_CYCLES out of range");
   end

   function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = g;
      for (int i = CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   function automatic logic [SETUP_W-1:0] gather(input logic [31:0]      mem,
                                                 input logic [CNT_W-1:0] base);
      logic [SETUP_W-1:0] w;
      logic [CNT_W-1:0]   a;
      w = '0;
      for (int i = 0; i < SETUP_W; i++) begin
         a = base + CNT_W'(i);
         w[SETUP_W-1-i] = mem[a];
      end
      return w;
   endfunction
   logic [CNT_W-1:0] rise_bin_q;
   logic [CNT_W-1:0] rise_gray_q;
   logic [CNT_W-1:0] fall_bin_q;
   logic [CNT_W-1:0] fall_gray_q;
   logic [31:0]      bit_mem_q;

   // rising edges sample sdi into a ring; entries stay put for 32 edges
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         rise_bin_q  <= '0;
         rise_gray_q <= '0;
         bit_mem_q   <= '0;
      end else begin
         bit_mem_q[rise_bin_q] <= sdi;
         rise_bin_q  <= rise_bin_q + CNT_ONE;
         rise_gray_q <= bin2gray(rise_bin_q + CNT_ONE);
      end
   end

   // falling edges only counted; output bit is chosen on the system side
   always_ff @(negedge sck or negedge rst_n) begin
      if (!rst_n) begin
         fall_bin_q  <= '0;
         fall_gray_q <= '0;
      end else begin
         fall_bin_q  <= fall_bin_q + CNT_ONE;
         fall_gray_q <= bin2gray(fall_bin_q + CNT_ONE);
      end
   end
   logic [SYNC_W-1:0] cnv_s_q;
   logic              cnv_lvl_q;
   logic [CNT_W-1:0]  rg1_q, rg2_q, rg3_q, fg1_q, fg2_q, fg3_q;
   logic [CNT_W-1:0]  r_q;
   logic [CNT_W-1:0]  f_q;

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnv_s_q   <= '0;
         cnv_lvl_q <= 1'b0;
         {rg1_q, rg2_q, rg3_q} <= '0;
         {fg1_q, fg2_q, fg3_q} <= '0;
         r_q <= '0;
         f_q <= '0;
      end else begin
         cnv_s_q <= {cnv_s_q[1:0], convert_strobe};
         if (cnv_s_q[1] == cnv_s_q[2]) cnv_lvl_q <= cnv_s_q[2];
         {rg3_q, rg2_q, rg1_q} <= {rg2_q, rg1_q, rise_gray_q};
         {fg3_q, fg2_q, fg1_q} <= {fg2_q, fg1_q, fall_gray_q};
         if (rg2_q == rg3_q) r_q <= gray2bin(rg3_q);
         if (fg2_q == fg3_q) f_q <= gray2bin(fg3_q);
      end
   end

   logic cnv_rise;
   logic cnv_fall;
   assign cnv_rise = (cnv_s_q[1] == cnv_s_q[2]) && cnv_s_q[2] && !cnv_lvl_q;
   assign cnv_fall = (cnv_s_q[1] == cnv_s_q[2]) && !cnv_s_q[2] && cnv_lvl_q;
   conv_state_t state_q;
   logic [15:0] conv_cnt_q;
   logic        eoc;
   assign eoc = (state_q == CONV_RUN) && (conv_cnt_q == 16'h0001);

   // once started the conversion ignores the strobe until it ends
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= CONV_IDLE;
         conv_cnt_q    <= '0;
         conv_active_q <= 1'b0;
         eoc_q         <= 1'b0;
      end else begin
         eoc_q <= eoc;
         case (state_q)
            CONV_IDLE: if (cnv_rise) begin
               state_q       <= CONV_RUN;
               conv_cnt_q    <= 16'(CONV_CYCLES);
               conv_active_q <= 1'b1;
            end
            CONV_RUN: begin
               conv_cnt_q <= conv_cnt_q - 16'h0001;
               if (eoc) begin
                  state_q       <= CONV_IDLE;
                  conv_active_q <= 1'b0;
               end
            end
            default: state_q <= CONV_IDLE;
         endcase
      end
   end
   logic [CNT_W-1:0]   r0_q;
   logic               cap_open_q;
   logic               shadow_ok_q;
   logic [SETUP_W-1:0] shadow_q;
   logic [CNT_W-1:0]   rise_seen;
   assign rise_seen = r_q - r0_q;

   // shadow fills only from the first 14 edges after the window opens
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r0_q        <= '0;
         cap_open_q  <= 1'b0;
         shadow_ok_q <= 1'b0;
         shadow_q    <= '0;
      end else begin
         if (cnv_rise) cap_open_q <= 1'b0;
         else if (cnv_fall) cap_open_q <= 1'b1;
         if (eoc) begin
            r0_q        <= r_q;
            shadow_ok_q <= 1'b0;
         end else if (cnv_fall) begin
            r0_q <= r_q;
         end else if (cap_open_q && !cnv_lvl_q && !shadow_ok_q && rise_seen >= CAP_BITS) begin
            shadow_q    <= gather(bit_mem_q, r0_q);
            shadow_ok_q <= 1'b1;
         end
      end
   end

   // commit at end of conversion, only a whole word with overwrite set
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         setup_word_q <= SETUP_RST;
      end else if (eoc && shadow_ok_q && shadow_q[OVERWRITE_BIT]) begin
         setup_word_q <= shadow_q;
      end
   end

   // decodes of the active voltage-source and scan fields
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {ref_int_en_q, ref_buf_en_q, temp_en_q} <= 3'h0;
         {scan_en_q, scan_temp_q, scan_update_q} <= 3'h0;
      end else begin
         case (setup_word_q[VSRC_HI:VSRC_LO])
            VSRC_INT_TEMP: {ref_int_en_q, ref_buf_en_q, temp_en_q} <= 3'h5;
            VSRC_EXT_TEMP: {ref_int_en_q, ref_buf_en_q, temp_en_q} <= 3'h1;
            VSRC_BUF_TEMP: {ref_int_en_q, ref_buf_en_q, temp_en_q} <= 3'h3;
            VSRC_EXT:      {ref_int_en_q, ref_buf_en_q, temp_en_q} <= 3'h0;
            VSRC_BUF:      {ref_int_en_q, ref_buf_en_q, temp_en_q} <= 3'h2;
            default:       {ref_int_en_q, ref_buf_en_q, temp_en_q} <= 3'h0;
         endcase
         case (setup_word_q[SCAN_HI:SCAN_LO])
            SCAN_OFF:    {scan_en_q, scan_temp_q, scan_update_q} <= 3'h0;
            SCAN_UPDATE: {scan_en_q, scan_temp_q, scan_update_q} <= 3'h1;
            SCAN_TEMP:   {scan_en_q, scan_temp_q, scan_update_q} <= 3'h6;
            SCAN_NOTEMP: {scan_en_q, scan_temp_q, scan_update_q} <= 3'h4;
            default:     {scan_en_q, scan_temp_q, scan_update_q} <= 3'h0;
         endcase
      end
   end
   logic [RES_W-1:0]   res_q;
   logic [SETUP_W-1:0] echo_q;
   logic [CNT_W-1:0]   f0_q;
   logic               lead_q;
   logic               active_q;
   logic [CNT_W-1:0]   pos;
   logic [CNT_W-1:0]   idx;
   logic [CNT_W-1:0]   len;
   logic [STREAM_W-1:0] word;
   assign pos  = f_q - f0_q;
   assign idx  = pos - {4'h0, lead_q};
   assign len  = setup_word_q[SETUP_ECHO_DISABLE_BIT] ? LEN_DATA : LEN_ECHO;
   assign word = {res_q, echo_q};

   // result and echoed setup latched at end of conversion
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         res_q     <= '0;
         echo_q    <= SETUP_RST;
         busy_en_q <= 1'b0;
      end else if (eoc) begin
         res_q     <= result_in;
         echo_q    <= setup_word_q;
         busy_en_q <= !cnv_lvl_q;
      end
   end

   // strobe edges and end of conversion outrank the falling-edge stream;
   // the bit lags sck by the crossing, a few system cycles
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         serial_out_pin_o    <= 1'b0;
         serial_out_pin_oe_n <= 1'b1;
         f0_q                <= '0;
         lead_q              <= 1'b0;
         active_q            <= 1'b0;
      end else if (cnv_rise) begin
         serial_out_pin_oe_n <= 1'b1;
         active_q            <= 1'b0;
      end else if (eoc) begin
         f0_q     <= f_q;
         lead_q   <= !cnv_lvl_q;
         active_q <= !cnv_lvl_q || cnv_fall;
         serial_out_pin_oe_n <= !(!cnv_lvl_q || cnv_fall);
         serial_out_pin_o    <= cnv_fall ? result_in[RES_W-1] : 1'b0;
      end else if (cnv_fall && state_q == CONV_IDLE) begin
         f0_q     <= f_q;
         lead_q   <= 1'b0;
         active_q <= 1'b1;
         serial_out_pin_oe_n <= 1'b0;
         serial_out_pin_o    <= res_q[RES_W-1];
      end else if (active_q && pos != '0) begin
         if (idx >= len) begin
            serial_out_pin_oe_n <= 1'b1;
            active_q            <= 1'b0;
         end else begin
            serial_out_pin_o <= word[STREAM_W-1-idx];
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_start_release: assert property (cnv_rise |=> serial_out_pin_oe_n)
      else $error("output not released at strobe rise");
   a_run_release: assert property (state_q == CONV_RUN |-> serial_out_pin_oe_n)
      else $error("output driven during conversion");
   a_conv_length: assert property (state_q == CONV_IDLE && cnv_rise
      |=> conv_active_q [*8])
      else $error("conversion ended early");
   a_busy_low: assert property (eoc && !cnv_lvl_q
      |=> !serial_out_pin_oe_n && !serial_out_pin_o && busy_en_q)
      else $error("busy low missing");
   a_busy_off: assert property (eoc && cnv_lvl_q && !cnv_fall
      |=> serial_out_pin_oe_n && !busy_en_q)
      else $error("busy not disabled");
   a_msb_drive: assert property (state_q == CONV_IDLE && cnv_fall && !eoc && !cnv_rise
      |=> !serial_out_pin_oe_n && serial_out_pin_o == res_q[RES_W-1])
      else $error("top bit not driven");
   a_partial_drop: assert property (eoc && !shadow_ok_q
      |=> $stable(setup_word_q))
      else $error("partial setup committed");
   a_keep_flag: assert property (eoc && shadow_ok_q && !shadow_q[OVERWRITE_BIT]
      |=> $stable(setup_word_q))
      else $error("setup changed without overwrite");
   a_commit_word: assert property (eoc && shadow_ok_q && shadow_q[OVERWRITE_BIT]
      |=> setup_word_q == $past(shadow_q))
      else $error("setup not committed");
   a_commit_gate: assert property (!eoc |=> $stable(setup_word_q))
      else $error("setup changed away from end of conversion");
   a_echo_len: assert property (active_q && setup_word_q[SETUP_ECHO_DISABLE_BIT]
      && !cnv_rise && !eoc && !cnv_fall && pos != '0 && idx >= LEN_DATA
      |=> serial_out_pin_oe_n)
      else $error("echo sent while disabled");
   a_ref_decode: assert property ($changed(setup_word_q)
      |=> ref_int_en_q == (setup_word_q[VSRC_HI:VSRC_LO] == VSRC_INT_TEMP))
      else $error("reference decode wrong");
   a_scan_decode: assert property ($changed(setup_word_q)
      |=> scan_en_q == setup_word_q[SCAN_HI])
      else $error("scan decode wrong");

   c_busy_eoc: cover property (eoc && !cnv_lvl_q);
   c_plain_eoc: cover property (eoc && cnv_lvl_q);
   c_commit: cover property (eoc && shadow_ok_q && shadow_q[OVERWRITE_BIT]);
   c_stream_end: cover property (active_q ##1 !active_q && serial_out_pin_oe_n);
endmodule

// ==== verification/adc_host_model.sv ====
// behavioural host for the converter serial port: strobe, serial clock, setup data in
// assumes the bench resolves the output pin with a pull-up and feeds that wire back
module adc_host_model (
   // serial pins toward the device
   output logic      sck,
   output logic      convert_strobe,
   output logic      sdi,
   // resolved serial output wire
   input  wire logic sdo_wire
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam real HALF = 62.5; // half period of the 125 ns link clock

   // pins quiet from time zero; outside frames only start moves the clock, to its idle level
   initial begin
      sck = 1'b0;
      convert_strobe = 1'b0;
      sdi = 1'b0;
   end

   // conversion start; idle level moves only while the strobe is high, so no bit counts
   task automatic start(input logic busy);
      convert_strobe = 1'b0;
      #60;
      convert_strobe = 1'b1;
      #40;
      sck = busy;
      #40;
      if (busy) convert_strobe = 1'b0;
   endtask

   // one frame after end of conversion, finished before the next start
   // sdo is taken on rising edges, well after the crossing lag of each fall
   task automatic frame(input logic busy, input logic [13:0] w, input int nw,
                        input int nclk, output logic [31:0] rd);
      rd = '0;
      convert_strobe = 1'b0;
      #100;
      for (int i = 0; i < nclk; i++) begin
         sdi = (i < nw) ? w[13-i] : 1'b0;
         if (busy) sck = 1'b0;
         #HALF;
         sck = 1'b1;
         rd = {rd[30:0], sdo_wire};
         #HALF;
         if (!busy) sck = 1'b0;
      end
      sdi = 1'b0; // held low so no new word starts
      #100;
   endtask
endmodule

// ==== verification/test_adc_setup_ctrl.sv ====
// self-checking bench for setup capture, conversion timing and serial readout
// assumes a behavioural host on the serial side and a pull-up on the output wire
module test_adc_setup_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   import adc_setup_pkg::*;

   localparam int CONV = 20; // shortened conversion keeps the run brief
   logic               clk_sys = 1'b0;
   logic               rst_n = 1'b0;
   logic               sck, convert_strobe, sdi, sdo_wire;
   logic [RES_W-1:0]   result_in = '0;
   logic               serial_out_pin_o, serial_out_pin_oe_n;
   logic               conv_active_q, eoc_q, busy_en_q;
   logic [SETUP_W-1:0] setup_word_q;
   logic               ref_int_en_q, ref_buf_en_q, temp_en_q;
   logic               scan_en_q, scan_temp_q, scan_update_q;
   int                 err_count = 0;
   int                 samples_checked = 0;
   int                 cycles = 0;
   logic [31:0]        rd;
   logic [13:0]        cur;
   logic [13:0]        tbl [5];
   logic [15:0]        r;

   always #5 clk_sys = ~clk_sys;
   // released pin reads as the pull-up level
   assign sdo_wire = serial_out_pin_oe_n ? 1'b1 : serial_out_pin_o;

   adc_setup_ctrl #(.CONV_CYCLES(CONV)) i_adc_setup_ctrl (
      .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .convert_strobe(convert_strobe),
      .sdi(sdi), .serial_out_pin_o(serial_out_pin_o),
      .serial_out_pin_oe_n(serial_out_pin_oe_n), .result_in(result_in),
      .conv_active_q(conv_active_q), .eoc_q(eoc_q), .busy_en_q(busy_en_q),
      .setup_word_q(setup_word_q), .ref_int_en_q(ref_int_en_q),
      .ref_buf_en_q(ref_buf_en_q), .temp_en_q(temp_en_q), .scan_en_q(scan_en_q),
      .scan_temp_q(scan_temp_q), .scan_update_q(scan_update_q));

   adc_host_model i_adc_host_model (
      .sck(sck), .convert_strobe(convert_strobe), .sdi(sdi), .sdo_wire(sdo_wire));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // hang guard, well above the few thousand cycles the tests need
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         $display("ERROR %0t timeout", $time);
         print_verdict();
      end
   end

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   // one conversion; busy picks the strobe level at end of conversion
   task automatic conv(input logic busy, input logic [15:0] v);
      @(negedge clk_sys);
      result_in = v;
      i_adc_host_model.start(busy);
      chk(serial_out_pin_oe_n === 1'b1, "output not released at start");
      repeat (8) @(negedge clk_sys);
      chk(serial_out_pin_oe_n === 1'b1, "output driven during conversion");
      for (int k = 0; k < 100 && eoc_q !== 1'b1; k++) @(negedge clk_sys);
      chk(eoc_q === 1'b1, "no end of conversion");
      repeat (3) @(negedge clk_sys);
      chk(busy_en_q === busy, "busy enable");
      if (busy) chk(sdo_wire === 1'b0, "no busy low");
   endtask

   // active word and its decodes, expected codes worked out per field
   task automatic chk_setup(input logic [13:0] w);
      logic [2:0] rf;
      logic [2:0] sc;
      case (w[VSRC_HI:VSRC_LO])
         3'h1: rf = 3'h5;
         3'h2: rf = 3'h1;
         3'h3: rf = 3'h3;
         3'h7: rf = 3'h2;
         default: rf = 3'h0;
      endcase
      case (w[SCAN_HI:SCAN_LO])
         2'h1: sc = 3'h1;
         2'h2: sc = 3'h6;
         2'h3: sc = 3'h4;
         default: sc = 3'h0;
      endcase
      chk(setup_word_q === w, "setup word");
      chk({ref_int_en_q, ref_buf_en_q, temp_en_q} === rf, "reference decode");
      chk({scan_en_q, scan_temp_q, scan_update_q} === sc, "scan decode");
   endtask

   initial begin
      tbl = '{14'h3FC9, 14'h3FD3, 14'h3FDD, 14'h3FF7, 14'h3FF9};
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk(serial_out_pin_oe_n === 1'b1, "reset output enable");
      cur = 14'h3FFF;
      chk_setup(cur);
      // each word is written after one end of conversion and applies at the next
      for (int j = 0; j < 6; j++) begin
         r = 16'hC35A - 16'(j * 257);
         conv(1'b0, r);
         chk_setup(cur);
         if (j < 5) begin
            i_adc_host_model.frame(1'b0, tbl[j], 14, 16, rd);
            chk(rd[15:0] === r, "readout");
            chk(serial_out_pin_oe_n === 1'b1, "release after 16");
            cur = tbl[j];
         end
      end
      $display("test decode done");
      // short word, then a full word with the overwrite flag low
      i_adc_host_model.frame(1'b0, 14'h2000, 10, 10, rd);
      conv(1'b0, 16'h1234);
      chk_setup(cur);
      i_adc_host_model.frame(1'b0, 14'h0C0A, 14, 16, rd);
      chk(rd[15:0] === 16'h1234, "new result after lost read");
      conv(1'b0, 16'h1234);
      chk_setup(cur);
      $display("test keep done");
      // echo on, then busy readout of result and setup in 31 clocks
      i_adc_host_model.frame(1'b0, 14'h3FC8, 14, 16, rd);
      conv(1'b0, 16'h4321);
      chk_setup(14'h3FC8);
      conv(1'b1, 16'hB00B);
      i_adc_host_model.frame(1'b1, 14'h3FF9, 14, 31, rd);
      chk(rd[30:15] === 16'hB00B, "busy result");
      chk(rd[14:1] === 14'h3FC8, "echoed setup");
      chk(serial_out_pin_oe_n === 1'b1, "release after 31");
      $display("test echo done");
      // busy with a 24 clock burst, then an unfinished read
      conv(1'b1, 16'h5AA5);
      chk_setup(14'h3FF9);
      i_adc_host_model.frame(1'b1, 14'h0000, 0, 24, rd);
      chk(rd[23:8] === 16'h5AA5, "burst result");
      chk(serial_out_pin_oe_n === 1'b1, "release after 17");
      conv(1'b1, 16'hFFEF);
      i_adc_host_model.frame(1'b1, 14'h0000, 0, 12, rd);
      chk(serial_out_pin_oe_n === 1'b0, "last bit not driven");
      chk(sdo_wire === 1'b0, "last bit value");
      conv(1'b0, 16'h0F0F);
      $display("test busy done");
      print_verdict();
   end
endmodule
